// [rtl/cbm_exec.v]
// Execution unit for relative branches, long call/jump, moves, table read
//
// Operation
// - Jump-if-carry-clear branches only with carry zero and keeps carry.
// - Jump-if-acc-nonzero branches when any accumulator bit is one.
// - Jump-if-acc-zero branches only when the accumulator is all zero.
// - Relative branches are 2 bytes, 2 cycles, PC+2 then add displacement.
// - Long call adds 3 to PC and pushes it low byte first, pre-incrementing.
// - Long call then loads PC high from byte two and low from byte three.
// - Long branch loads PC high from byte two and low from byte three.
// - Byte copy writes the source to the destination and nothing else.
// - Direct-to-direct copy is 3 bytes, 2 cycles, source byte first.
// - Bit copy moves one bit between carry and any addressable bit.
// - Data pointer load puts byte two in the high half, byte three low.
// - Code table read loads A from code at unsigned A plus 16-bit base.
// - PC base is the next instruction address; pointer base is kept.
`timescale 1ns/1ns
`include "cbm_exec_regs.vh"

module cbm_exec (
  input  wire        clock,
  input  wire        rst_n,
  output reg  [15:0] pm_addr,
  input  wire [7:0]  pm_rdata,
  output reg  [7:0]  dm_addr,
  output reg  [7:0]  dm_wdata,
  output reg         dm_we,
  output wire        dm_sfr,
  input  wire [7:0]  dm_rdata,
  output reg         instr_done,
  output reg         op_unsupported,
  output wire [15:0] pc_out,
  output wire [7:0]  acc_out,
  output wire [7:0]  sp_out,
  output wire [15:0] data_pointer_out,
  output wire [7:0]  psw_out
);

  localparam S_FETCH = 8'h01;
  localparam S_B2    = 8'h02;
  localparam S_B3    = 8'h04;
  localparam S_PTR   = 8'h08;
  localparam S_SRC   = 8'h10;
  localparam S_DST   = 8'h20;
  localparam S_WAIT  = 8'h40;

  localparam C_NOP  = 4'h0;
  localparam C_MOV  = 4'h1;
  localparam C_BR   = 4'h2;
  localparam C_CALL = 4'h3;
  localparam C_JMP  = 4'h4;
  localparam C_DATA_POINTER = 4'h5;
  localparam C_CODE = 4'h6;
  localparam C_CBIT = 4'h7;
  localparam C_BITC = 4'h8;

  localparam K_A    = 3'h0;
  localparam K_RN   = 3'h1;
  localparam K_DIR  = 3'h2;
  localparam K_IND  = 3'h3;
  localparam K_IMM  = 3'h4;
  localparam K_NONE = 3'h5;

  reg [7:0]  state_reg;
  reg [7:0]  state_next;
  reg [15:0] pc_reg;
  reg [15:0] pc_next;
  reg [7:0]  acc_reg;
  reg [7:0]  acc_next;
  reg [7:0]  sp_reg;
  reg [7:0]  sp_next;
  reg [7:0]  dpl_reg;
  reg [7:0]  dpl_next;
  reg [7:0]  dph_reg;
  reg [7:0]  dph_next;
  reg [7:0]  psw_reg;
  reg [7:0]  psw_next;
  reg [7:0]  op_reg;
  reg [7:0]  b1_reg;
  reg [7:0]  b2_reg;
  reg [7:0]  ptr_reg;
  reg [7:0]  ptr_next;
  reg [7:0]  tmp_reg;
  reg [7:0]  tmp_next;
  reg [3:0]  cnt_reg;

  reg [3:0]  cls;
  reg [1:0]  len;
  reg        two_cyc;
  reg [2:0]  src_k;
  reg [2:0]  dst_k;
  reg        acc_dir;
  reg [7:0]  rd_val;

  wire        carry    = psw_reg[`CBM_PSW_CY];
  wire [1:0]  bank     = psw_reg[`CBM_PSW_BANK_HI:`CBM_PSW_BANK_LO];
  wire [7:0]  rn_addr  = {3'h0, bank, op_reg[2:0]};
  wire [7:0]  ri_addr  = {3'h0, bank, 2'h0, op_reg[0]};
  wire [7:0]  dst_dir  = (op_reg == `CBM_OP_DIR_DIR) ? b2_reg : b1_reg;
  wire [7:0]  imm      = (op_reg == `CBM_OP_DIR_IMM) ? b2_reg : b1_reg;
  wire [7:0]  bit_byte = b1_reg[7] ? {b1_reg[7:3], 3'h0}
                                   : {`CBM_BIT_RAM_HI, b1_reg[6:3]};
  wire [2:0]  bit_idx  = b1_reg[2:0];
  wire [15:0] rel_ext  = {{8{b1_reg[7]}}, b1_reg};
  wire [15:0] code_base = (op_reg == `CBM_OP_CODE_PC) ?
                          pc_reg : {dph_reg, dpl_reg};
  wire [15:0] code_addr = code_base + {8'h00, acc_reg};
  wire [3:0]  last_cnt  = two_cyc ?
                          (`CBM_MACH_CLKS + `CBM_MACH_CLKS - 4'h1) :
                          (`CBM_MACH_CLKS - 4'h1);
  wire        needs_ptr = (src_k == K_IND) || (dst_k == K_IND);

  reg         take;

  assign dm_sfr   = acc_dir & dm_addr[7];
  assign pc_out   = pc_reg;
  assign acc_out  = acc_reg;
  assign sp_out   = sp_reg;
  assign data_pointer_out = {dph_reg, dpl_reg};
  assign psw_out  = psw_reg;

  // Decode of the latched opcode
  always @*
  begin
    cls     = C_NOP;
    len     = 2'h1;
    two_cyc = 1'b0;
    src_k   = K_NONE;
    dst_k   = K_NONE;
    casez (op_reg)
      8'b1110_1???: begin cls = C_MOV; src_k = K_RN; dst_k = K_A; end
      `CBM_OP_A_DIR: begin cls = C_MOV; src_k = K_DIR; dst_k = K_A; len = 2'h2; end
      8'b1110_011?: begin cls = C_MOV; src_k = K_IND; dst_k = K_A; end
      `CBM_OP_A_IMM: begin cls = C_MOV; src_k = K_IMM; dst_k = K_A; len = 2'h2; end
      8'b1111_1???: begin cls = C_MOV; src_k = K_A; dst_k = K_RN; end
      8'b1010_1???: begin cls = C_MOV; src_k = K_DIR; dst_k = K_RN; len = 2'h2; two_cyc = 1'b1; end
      8'b0111_1???: begin cls = C_MOV; src_k = K_IMM; dst_k = K_RN; len = 2'h2; end
      `CBM_OP_DIR_A: begin cls = C_MOV; src_k = K_A; dst_k = K_DIR; len = 2'h2; end
      8'b1000_1???: begin cls = C_MOV; src_k = K_RN; dst_k = K_DIR; len = 2'h2; two_cyc = 1'b1; end
      `CBM_OP_DIR_DIR: begin cls = C_MOV; src_k = K_DIR; dst_k = K_DIR; len = 2'h3; two_cyc = 1'b1; end
      8'b1000_011?: begin cls = C_MOV; src_k = K_IND; dst_k = K_DIR; len = 2'h2; two_cyc = 1'b1; end
      `CBM_OP_DIR_IMM: begin cls = C_MOV; src_k = K_IMM; dst_k = K_DIR; len = 2'h3; two_cyc = 1'b1; end
      8'b1111_011?: begin cls = C_MOV; src_k = K_A; dst_k = K_IND; end
      8'b1010_011?: begin cls = C_MOV; src_k = K_DIR; dst_k = K_IND; len = 2'h2; two_cyc = 1'b1; end
      8'b0111_011?: begin cls = C_MOV; src_k = K_IMM; dst_k = K_IND; len = 2'h2; end
      `CBM_OP_JNC, `CBM_OP_JNZ, `CBM_OP_JZ:
        begin cls = C_BR; len = 2'h2; two_cyc = 1'b1; end
      `CBM_OP_CALL: begin cls = C_CALL; len = 2'h3; two_cyc = 1'b1; end
      `CBM_OP_JMP:  begin cls = C_JMP; len = 2'h3; two_cyc = 1'b1; end
      `CBM_OP_DATA_POINTER: begin cls = C_DATA_POINTER; len = 2'h3; two_cyc = 1'b1; end
      `CBM_OP_CODE_DATA_POINTER, `CBM_OP_CODE_PC:
        begin cls = C_CODE; two_cyc = 1'b1; end
      `CBM_OP_C_BIT: begin cls = C_CBIT; len = 2'h2; end
      `CBM_OP_BIT_C: begin cls = C_BITC; len = 2'h2; two_cyc = 1'b1; end
      default: cls = C_NOP;
    endcase
  end

  // Branch conditions; no flag or accumulator is written on this path
  always @*
  begin
    case (op_reg)
      `CBM_OP_JNC: take = ~carry;
      `CBM_OP_JNZ: take = |acc_reg;
      `CBM_OP_JZ:  take = ~(|acc_reg);
      default:     take = 1'b0;
    endcase
  end

  // Data-space access per state, register updates and sequencing
  always @*
  begin
    state_next = state_reg;
    pc_next    = pc_reg;
    acc_next   = acc_reg;
    sp_next    = sp_reg;
    dpl_next   = dpl_reg;
    dph_next   = dph_reg;
    psw_next   = psw_reg;
    ptr_next   = ptr_reg;
    tmp_next   = tmp_reg;
    pm_addr    = pc_reg;
    dm_addr    = 8'h00;
    dm_wdata   = 8'h00;
    dm_we      = 1'b0;
    acc_dir    = 1'b1;
    case (state_reg)
      S_FETCH:
      begin
        pc_next    = pc_reg + 16'h0001;
        state_next = S_B2;
      end
      S_B2:
      begin
        if (len != 2'h1)
          pc_next = pc_reg + 16'h0001;
        state_next = (len == 2'h3) ? S_B3 : (needs_ptr ? S_PTR : S_SRC);
        if (len == 2'h1)
          state_next = needs_ptr ? S_PTR : S_SRC;
      end
      S_B3:
      begin
        pc_next    = pc_reg + 16'h0001;
        state_next = needs_ptr ? S_PTR : S_SRC;
      end
      S_PTR:
      begin
        dm_addr    = ri_addr;
        ptr_next   = rd_val;
        state_next = S_SRC;
      end
      S_SRC:
      begin
        state_next = S_DST;
        case (cls)
          C_MOV:
            case (src_k)
              K_A:   tmp_next = acc_reg;
              K_RN:  begin dm_addr = rn_addr; tmp_next = rd_val; end
              K_DIR: begin dm_addr = b1_reg; tmp_next = rd_val; end
              K_IND: begin dm_addr = ptr_reg; acc_dir = 1'b0; tmp_next = rd_val; end
              default: tmp_next = imm;
            endcase
          C_CBIT:
          begin
            dm_addr = bit_byte;
            psw_next[`CBM_PSW_CY] = rd_val[bit_idx];
          end
          C_BITC:
          begin
            dm_addr  = bit_byte;
            tmp_next = rd_val;
          end
          C_CALL:
          begin
            // Stack lives in indirect RAM, pre-incremented pointer
            acc_dir  = 1'b0;
            dm_addr  = sp_reg + 8'h01;
            dm_wdata = pc_reg[7:0];
            dm_we    = 1'b1;
            sp_next  = sp_reg + 8'h01;
          end
          C_BR:
            if (take)
              pc_next = pc_reg + rel_ext;
          C_JMP:  pc_next = {b1_reg, b2_reg};
          C_DATA_POINTER:
          begin
            dph_next = b1_reg;
            dpl_next = b2_reg;
          end
          C_CODE:
          begin
            pm_addr  = code_addr;
            acc_next = pm_rdata;
          end
          default: tmp_next = tmp_reg;
        endcase
      end
      S_DST:
      begin
        state_next = S_WAIT;
        case (cls)
          C_MOV:
          begin
            dm_wdata = tmp_reg;
            case (dst_k)
              K_A:   acc_next = tmp_reg;
              K_RN:  begin dm_addr = rn_addr; dm_we = 1'b1; end
              K_DIR: begin dm_addr = dst_dir; dm_we = 1'b1; end
              default: begin dm_addr = ptr_reg; acc_dir = 1'b0; dm_we = 1'b1; end
            endcase
          end
          C_BITC:
          begin
            dm_addr  = bit_byte;
            dm_wdata = (tmp_reg & ~(8'h01 << bit_idx)) |
                       ({7'h00, carry} << bit_idx);
            dm_we    = 1'b1;
          end
          C_CALL:
          begin
            acc_dir  = 1'b0;
            dm_addr  = sp_reg + 8'h01;
            dm_wdata = pc_reg[15:8];
            dm_we    = 1'b1;
            sp_next  = sp_reg + 8'h01;
            pc_next  = {b1_reg, b2_reg};
          end
          default: dm_we = 1'b0;
        endcase
      end
      S_WAIT:
        if (cnt_reg >= last_cnt)
          state_next = S_FETCH;
      default: state_next = S_FETCH;
    endcase
    if (state_reg == S_FETCH)
      pm_addr = pc_reg;
    // Writes that hit registers held here are absorbed, not sent to memory
    if (dm_we && acc_dir)
      case (dm_addr)
        `CBM_ADDR_ACC: begin acc_next = dm_wdata; dm_we = 1'b0; end
        `CBM_ADDR_SP:  begin sp_next  = dm_wdata; dm_we = 1'b0; end
        `CBM_ADDR_DPL: begin dpl_next = dm_wdata; dm_we = 1'b0; end
        `CBM_ADDR_DPH: begin dph_next = dm_wdata; dm_we = 1'b0; end
        `CBM_ADDR_PSW: begin psw_next = dm_wdata; dm_we = 1'b0; end
        default: dm_we = 1'b1;
      endcase
  end

  // Read value of the current access; internal registers shadow memory
  always @*
  begin
    rd_val = dm_rdata;
    if (acc_dir)
      case (dm_addr)
        `CBM_ADDR_ACC: rd_val = acc_reg;
        `CBM_ADDR_SP:  rd_val = sp_reg;
        `CBM_ADDR_DPL: rd_val = dpl_reg;
        `CBM_ADDR_DPH: rd_val = dph_reg;
        `CBM_ADDR_PSW: rd_val = psw_reg;
        default:       rd_val = dm_rdata;
      endcase
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg      <= S_FETCH;
      pc_reg         <= `CBM_PC_RST;
      acc_reg        <= `CBM_ACC_RST;
      sp_reg         <= `CBM_SP_RST;
      psw_reg        <= `CBM_PSW_RST;
      {dph_reg, dpl_reg} <= `CBM_DATA_POINTER_RST;
      op_reg         <= 8'h00;
      b1_reg         <= 8'h00;
      b2_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      tmp_reg        <= 8'h00;
      cnt_reg        <= 4'h0;
      instr_done     <= 1'b0;
      op_unsupported <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      acc_reg    <= acc_next;
      sp_reg     <= sp_next;
      dpl_reg    <= dpl_next;
      dph_reg    <= dph_next;
      psw_reg    <= psw_next;
      ptr_reg    <= ptr_next;
      tmp_reg    <= tmp_next;
      cnt_reg    <= (state_reg == S_FETCH) ? 4'h1 : cnt_reg + 4'h1;
      instr_done <= (state_reg == S_WAIT) && (state_next == S_FETCH);
      op_unsupported <= (state_reg == S_B2) && (cls == C_NOP);
      if (state_reg == S_FETCH)
        op_reg <= pm_rdata;
      if ((state_reg == S_B2) && (len != 2'h1))
        b1_reg <= pm_rdata;
      if (state_reg == S_B3)
        b2_reg <= pm_rdata;
    end
  end

endmodule // cbm_exec

// [rtl/cbm_exec_regs.vh]
// Constants for the branch, move and table-read execution unit
`ifndef CBM_EXEC_REGS_VH
`define CBM_EXEC_REGS_VH

// Clocks per machine cycle; every instruction is padded to whole cycles
`define CBM_MACH_CLKS     4'h6

// Reset values
`define CBM_PC_RST        16'h0000
`define CBM_ACC_RST       8'h00
`define CBM_SP_RST        8'h07
`define CBM_PSW_RST       8'h00
`define CBM_DATA_POINTER_RST      16'h0000

// Direct addresses of the registers held inside the unit
`define CBM_ADDR_ACC      8'hE0
`define CBM_ADDR_SP       8'h81
`define CBM_ADDR_DPL      8'h82
`define CBM_ADDR_DPH      8'h83
`define CBM_ADDR_PSW      8'hD0

// Status word fields
`define CBM_PSW_CY        7
`define CBM_PSW_BANK_HI   4
`define CBM_PSW_BANK_LO   3

// Base of the bit-addressable RAM bytes, upper nibble
`define CBM_BIT_RAM_HI    4'h2

// Opcodes with a single encoding
`define CBM_OP_JNC        8'h50
`define CBM_OP_JNZ        8'h70
`define CBM_OP_JZ         8'h60
`define CBM_OP_CALL       8'h12
`define CBM_OP_JMP        8'h02
`define CBM_OP_A_DIR      8'hE5
`define CBM_OP_A_IMM      8'h74
`define CBM_OP_DIR_A      8'hF5
`define CBM_OP_DIR_DIR    8'h85
`define CBM_OP_DIR_IMM    8'h75
`define CBM_OP_C_BIT      8'hA2
`define CBM_OP_BIT_C      8'h92
`define CBM_OP_DATA_POINTER       8'h90
`define CBM_OP_CODE_DATA_POINTER  8'h93
`define CBM_OP_CODE_PC    8'h83

`endif

// [test/cbm_exec_monitor.sv]
// Port checker for the branch, move and table-read execution unit
`timescale 1ns/1ns
`include "cbm_exec_regs.vh"

module cbm_exec_monitor (
  input wire        clock,
  input wire        rst_n,
  input wire [15:0] pm_addr,
  input wire [7:0]  pm_rdata,
  input wire [7:0]  dm_addr,
  input wire [7:0]  dm_wdata,
  input wire        dm_we,
  input wire        dm_sfr,
  input wire [7:0]  dm_rdata,
  input wire        instr_done,
  input wire        op_unsupported,
  input wire [15:0] pc_out,
  input wire [7:0]  acc_out,
  input wire [7:0]  sp_out,
  input wire [15:0] data_pointer_out,
  input wire [7:0]  psw_out
);
  reg         v_reg;
  reg  [3:0]  k_reg;
  reg  [7:0]  op_q, b2_q, b3_q, acc_q, sp_q, psw_q;
  reg  [15:0] pc_q, dp_q;
  wire [15:0] rel_w = {{8{b2_q[7]}}, b2_q};
  wire [15:0] nx2_w = pc_q + 16'h0002;
  wire [15:0] nx3_w = pc_q + 16'h0003;
  wire        fin_w = instr_done && v_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Clocks since fetch; saturates so a stall cannot wrap into a false match
  always @(posedge clock)
  begin
    if (!rst_n)
      v_reg <= 1'b0;
    else if (instr_done)
      v_reg <= 1'b1;
    if (!rst_n)
      k_reg <= 4'h0;
    else if (instr_done)
      k_reg <= 4'h1;
    else if (k_reg != 4'hF)
      k_reg <= k_reg + 4'h1;
    if (instr_done)
    begin
      op_q <= pm_rdata;
      pc_q <= pm_addr;
      acc_q <= acc_out;
      sp_q <= sp_out;
      psw_q <= psw_out;
      dp_q <= data_pointer_out;
    end
    if (k_reg == 4'h1)
      b2_q <= pm_rdata;
    if (k_reg == 4'h2)
      b3_q <= pm_rdata;
  end

  carry_branch_a:
    assert property (fin_w && op_q == `CBM_OP_JNC |-> psw_out == psw_q &&
      pm_addr == nx2_w + (psw_q[`CBM_PSW_CY] ? 16'h0000 : rel_w))
    else $error("carry-clear branch wrong");
  nonzero_branch_a:
    assert property (fin_w && op_q == `CBM_OP_JNZ |-> acc_out == acc_q &&
      psw_out == psw_q && pm_addr == nx2_w + (acc_q != 8'h00 ? rel_w : 16'h0000))
    else $error("nonzero branch wrong");
  zero_branch_a:
    assert property (fin_w && op_q == `CBM_OP_JZ |-> acc_out == acc_q &&
      psw_out == psw_q && pm_addr == nx2_w + (acc_q == 8'h00 ? rel_w : 16'h0000))
    else $error("zero branch wrong");
  call_push_a:
    assert property (v_reg && op_q == `CBM_OP_CALL && k_reg == 4'h3 |-> dm_we &&
      !dm_sfr && dm_addr == sp_q + 8'h01 && dm_wdata == nx3_w[7:0] ##1
      dm_we && !dm_sfr && dm_addr == sp_q + 8'h02 && dm_wdata == nx3_w[15:8])
    else $error("call push wrong");
  call_target_a:
    assert property (fin_w && op_q == `CBM_OP_CALL |-> pm_addr == {b2_q, b3_q}
      && sp_out == sp_q + 8'h02 && psw_out == psw_q)
    else $error("call target wrong");
  long_branch_a:
    assert property (fin_w && op_q == `CBM_OP_JMP |-> pm_addr == {b2_q, b3_q}
      && psw_out == psw_q)
    else $error("long branch wrong");
  data_pointer_load_a:
    assert property (fin_w && op_q == `CBM_OP_DATA_POINTER |->
      data_pointer_out == {b2_q, b3_q} && psw_out == psw_q)
    else $error("pointer load wrong");
  table_read_a:
    assert property (v_reg && k_reg == 4'h2 && (op_q == `CBM_OP_CODE_DATA_POINTER ||
      op_q == `CBM_OP_CODE_PC) |-> pm_addr == {8'h00, acc_q} +
      (op_q == `CBM_OP_CODE_PC ? pc_q + 16'h0001 : dp_q) ##1
      acc_out == $past(pm_rdata) && data_pointer_out == dp_q && psw_out == psw_q)
    else $error("table read wrong");
  copy_order_a:
    assert property (v_reg && op_q == `CBM_OP_DIR_DIR && k_reg == 4'h3 &&
      !b2_q[7] && !b3_q[7] |-> !dm_we && dm_addr == b2_q ##1 dm_we &&
      dm_addr == b3_q && dm_wdata == $past(dm_rdata))
    else $error("direct copy wrong");
  two_cycle_a:
    assert property (fin_w && op_q inside {`CBM_OP_JNC, `CBM_OP_JNZ, `CBM_OP_JZ,
      `CBM_OP_CALL, `CBM_OP_JMP, `CBM_OP_DIR_DIR, `CBM_OP_DIR_IMM,
      `CBM_OP_BIT_C, `CBM_OP_DATA_POINTER, `CBM_OP_CODE_DATA_POINTER, `CBM_OP_CODE_PC}
      |-> k_reg == 4'hC)
    else $error("instruction length wrong");
endmodule // cbm_exec_monitor

bind cbm_exec cbm_exec_monitor u_mon (.clock(clock), .rst_n(rst_n),
  .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
  .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_sfr(dm_sfr), .dm_rdata(dm_rdata),
  .instr_done(instr_done), .op_unsupported(op_unsupported),
  .pc_out(pc_out), .acc_out(acc_out), .sp_out(sp_out),
  .data_pointer_out(data_pointer_out), .psw_out(psw_out));

// [test/cbm_mem_model.sv]
// Program memory and internal data memory facing the execution unit
`timescale 1ns/1ns

module cbm_mem_model (
  input  wire        clock,
  input  wire [15:0] pm_addr,
  output wire [7:0]  pm_rdata,
  input  wire [7:0]  dm_addr,
  input  wire [7:0]  dm_wdata,
  input  wire        dm_we,
  input  wire        dm_sfr,
  output wire [7:0]  dm_rdata
);
  reg [7:0] rom [0:65535];
  reg [7:0] ram [0:255];
  reg [7:0] sfr [0:127];
  integer   i;

  // Code bytes follow the low byte of their address, so a wrong low byte of the table sum reads a wrong byte
  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      rom[i] = i[7:0] ^ 8'h5A;
    for (i = 0; i < 256; i = i + 1)
      ram[i] = 8'h00;
    for (i = 0; i < 128; i = i + 1)
      sfr[i] = 8'h00;
  end

  assign pm_rdata = rom[pm_addr];
  assign dm_rdata = dm_sfr ? sfr[dm_addr[6:0]] : ram[dm_addr];

  always @(posedge clock)
    if (dm_we && dm_sfr)
      sfr[dm_addr[6:0]] <= dm_wdata;
    else if (dm_we)
      ram[dm_addr] <= dm_wdata;
endmodule // cbm_mem_model

// [test/cbm_exec_tb_top.sv]
// Self-checking bench running a short program through the execution unit
`timescale 1ns/1ns
`include "cbm_exec_regs.vh"
`define CBM_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module cbm_exec_tb_top;
  typedef struct packed {
    logic [23:0] code;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  sp;
    logic        cy;
    logic [3:0]  cyc;
  } cbm_row_t;

  logic        clock, rst_n, dm_we, dm_sfr, instr_done, op_unsupported;
  logic [15:0] pm_addr, pc_out, data_pointer_out, a;
  logic [7:0]  pm_rdata, dm_addr, dm_wdata, dm_rdata, acc_out, sp_out, psw_out;
  logic [7:0]  unsup_seen;
  cbm_row_t    tbl [0:18];
  int          fails, samples_checked, i, n;

  cbm_exec dut (.clock(clock), .rst_n(rst_n), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .dm_sfr(dm_sfr), .dm_rdata(dm_rdata),
    .instr_done(instr_done), .op_unsupported(op_unsupported),
    .pc_out(pc_out), .acc_out(acc_out), .sp_out(sp_out),
    .data_pointer_out(data_pointer_out), .psw_out(psw_out));
  cbm_mem_model mem (.clock(clock), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_sfr(dm_sfr),
    .dm_rdata(dm_rdata));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  always @(posedge clock)
    if (!rst_n)
      unsup_seen <= 8'h00;
    else if (op_unsupported === 1'b1)
      unsup_seen <= unsup_seen + 8'h01;

  task automatic wrap_up;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  task automatic wait_done(output int cnt);
  begin
    cnt = 0;
    do
    begin
      @(posedge clock);
      #1;
      cnt++;
    end while (instr_done !== 1'b1 && cnt < 40);
    if (cnt >= 40)
    begin
      fails++;
      wrap_up();
    end
  end
  endtask

  initial
  begin
    rst_n = 1'b0;
    fails = 0;
    samples_checked = 0;
    // Each row starts where the row before it left the program counter
    tbl[0] = {24'h600200, 16'h0004, 8'h00, 8'h07, 1'b0, 4'hC};
    tbl[1] = {24'h748000, 16'h0006, 8'h80, 8'h07, 1'b0, 4'h6};
    tbl[2] = {24'h502000, 16'h0028, 8'h80, 8'h07, 1'b0, 4'hC};
    tbl[3] = {24'h70E000, 16'h000A, 8'h80, 8'h07, 1'b0, 4'hC};
    tbl[4] = {24'h604000, 16'h000C, 8'h80, 8'h07, 1'b0, 4'hC};
    tbl[5] = {24'h9040F0, 16'h000F, 8'h80, 8'h07, 1'b0, 4'hC};
    tbl[6] = {24'h930000, 16'h0010, 8'h2A, 8'h07, 1'b0, 4'hC};
    tbl[7] = {24'h830000, 16'h0011, 8'h61, 8'h07, 1'b0, 4'hC};
    tbl[8] = {24'h75D080, 16'h0014, 8'h61, 8'h07, 1'b1, 4'hC};
    tbl[9] = {24'h507F00, 16'h0016, 8'h61, 8'h07, 1'b1, 4'hC};
    tbl[10] = {24'h922100, 16'h0018, 8'h61, 8'h07, 1'b1, 4'hC};
    tbl[11] = {24'h121234, 16'h1234, 8'h61, 8'h09, 1'b1, 4'hC};
    tbl[12] = {24'h852430, 16'h1237, 8'h61, 8'h09, 1'b1, 4'hC};
    tbl[13] = {24'hE53000, 16'h1239, 8'h02, 8'h09, 1'b1, 4'h6};
    tbl[14] = {24'h600500, 16'h123B, 8'h02, 8'h09, 1'b1, 4'hC};
    tbl[15] = {24'hA22200, 16'h123D, 8'h02, 8'h09, 1'b0, 4'h6};
    tbl[16] = {24'h02FFFD, 16'hFFFD, 8'h02, 8'h09, 1'b0, 4'hC};
    tbl[17] = {24'h703000, 16'h002F, 8'h02, 8'h09, 1'b0, 4'hC};
    tbl[18] = {24'hA50000, 16'h0030, 8'h02, 8'h09, 1'b0, 4'h6};
    @(posedge clock);
    #1;
    a = 16'h0000;
    for (i = 0; i < 19; i++)
    begin
      mem.rom[a] = tbl[i].code[23:16];
      mem.rom[a + 16'h0001] = tbl[i].code[15:8];
      mem.rom[a + 16'h0002] = tbl[i].code[7:0];
      a = tbl[i].pc;
    end
    repeat (7) @(posedge clock);
    #1;
    rst_n = 1'b1;
    for (i = 0; i < 19; i++)
    begin
      wait_done(n);
      `CBM_CHK("pc", tbl[i].pc, pc_out)
      `CBM_CHK("acc", tbl[i].acc, acc_out)
      `CBM_CHK("sp", tbl[i].sp, sp_out)
      `CBM_CHK("carry", tbl[i].cy, psw_out[`CBM_PSW_CY])
      if (i > 0)
        `CBM_CHK("cycles", tbl[i].cyc, n[3:0])
      $display("row %0d done", i);
    end
    `CBM_CHK("refused", 8'h01, unsup_seen)
    `CBM_CHK("ret low", 8'h1B, mem.ram[8'h08])
    `CBM_CHK("ret high", 8'h00, mem.ram[8'h09])
    `CBM_CHK("bit byte", 8'h02, mem.ram[8'h24])
    `CBM_CHK("copy dest", 8'h02, mem.ram[8'h30])
    `CBM_CHK("data_pointer", 16'h40F0, data_pointer_out)
    $display("memory test done");
    rst_n = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    `CBM_CHK("rst pc", `CBM_PC_RST, pc_out)
    `CBM_CHK("rst acc", `CBM_ACC_RST, acc_out)
    `CBM_CHK("rst sp", `CBM_SP_RST, sp_out)
    `CBM_CHK("rst data_pointer", `CBM_DATA_POINTER_RST, data_pointer_out)
    `CBM_CHK("rst psw", `CBM_PSW_RST, psw_out)
    rst_n = 1'b1;
    wait_done(n);
    `CBM_CHK("pc after", 16'h0004, pc_out)
    $display("reset test done");
    wrap_up();
  end
endmodule // cbm_exec_tb_top
